//--- inc/osp_pkg.sv
// shared constants for the otp self-programming controller and its cpu end
package osp_pkg;
  // device register selects on the link
  localparam logic [2:0] SEL_TBL_PTR  = 3'h0;
  localparam logic [2:0] SEL_WORD_LO  = 3'h1;
  localparam logic [2:0] SEL_WORD_HI  = 3'h2;
  localparam logic [2:0] SEL_CONTROL  = 3'h3;
  // program_control field positions
  localparam int CTRL_ARM_BIT = 3;
  localparam int CTRL_GO_BIT  = 2;
  // reset value and blank-word read value
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] BLANK_BYTE = 8'h00;
  // write cycle length in subsidiary clock rising edges
  localparam int BURN_TICKS_DEF = 8;
  // host: core clocks per subsidiary clock half period, warm-up edges
  localparam int SUB_DIV_DEF  = 4;
  localparam int SUB_WARM_DEF = 4;
  // host ahb-lite register byte offsets
  localparam logic [7:0] OFF_WORD = 8'h00;
  localparam logic [7:0] OFF_CMD  = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0c;
  // host command / status / control bits
  localparam int CMD_PROG_BIT   = 0;
  localparam int CMD_READ_BIT   = 1;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_VFAIL_BIT = 1;
  localparam int STAT_STABLE_BIT = 2;
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int CTRL_GPIO_BIT  = 1;

  typedef enum logic [0:0] {
    D_IDLE = 1'b0,
    D_BURN = 1'b1
  } osp_dev_state_t;

  typedef enum logic [3:0] {
    H_IDLE  = 4'h0,
    H_WARM  = 4'h1,
    H_PTR   = 4'h2,
    H_LOW   = 4'h3,
    H_HIGH  = 4'h4,
    H_CLR   = 4'h5,
    H_ARM   = 4'h6,
    H_GO    = 4'h7,
    H_HOLD  = 4'h8,
    H_WAIT  = 4'h9,
    H_RDPTR = 4'ha,
    H_RD    = 4'hb,
    H_RDW   = 4'hc
  } osp_host_state_t;
endpackage

//--- inc/osp_link_if.sv
// link between the cpu end and the otp self-programming device end
`timescale 1ns/1ps
interface osp_link_if (
  input wire logic core_clk_i,
  input wire logic reset_n_i
);
  logic       instr_stb;  // one pulse per cpu instruction cycle
  logic       reg_wr;
  logic       reg_rd;
  logic       tab_rd;     // table_read_last_page
  logic [2:0] reg_sel;
  logic [7:0] reg_wdata;
  logic       sleep;      // cpu in idle or sleep
  logic       sub_clk;    // subsidiary low-speed clock, sampled as a pin
  logic       stall;
  logic       rd_valid;
  logic [7:0] reg_rdata;
  logic [7:0] rd_low;
  logic [7:0] rd_high;    // table_high_byte

  modport dev (
    input  instr_stb, reg_wr, reg_rd, tab_rd, reg_sel, reg_wdata, sleep, sub_clk,
    output stall, rd_valid, reg_rdata, rd_low, rd_high
  );
  modport host (
    output instr_stb, reg_wr, reg_rd, tab_rd, reg_sel, reg_wdata, sleep, sub_clk,
    input  stall, rd_valid, reg_rdata, rd_low, rd_high
  );
endinterface

//--- logic/osp_sync2.sv
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module osp_sync2 (
  input  wire logic core_clk_i,
  input  wire logic reset_n_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta;

  // first stage feeds only the second
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta <= 1'b0;
      q_o  <= 1'b0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

//--- logic/osp_otp_dev.sv
// device end: otp self-programming registers, write cycle and last-page store
`timescale 1ns/1ps
// Summary of operation
// [RQ1] writes hit last page only, once each
// [RQ2] vpp shared pin never driven as output; the host drives it when idle if CTRL_GPIO_BIT is set
// [RQ3] low data byte, read/write, resets zero
// [RQ4] high byte: bit7 zero on narrow variant
// [RQ5] control bit 3 arms programming
// [RQ6] unarmed blocks writes; arm clears when done
// [RQ7] bit 2 starts, reads busy, self-clears
// [RQ8] go ignored unless arm set earlier
// [RQ9] arm and go together never start
// [RQ10] go only in instruction right after arm
// [RQ11] cpu halted during the write cycle
// [RQ12] write uses pointer and data registers
// [RQ13] interrupts off around arm and go
// [RQ14] table read: low byte, high byte apart
// [RQ15] sleep during cycle makes write fail
// [RQ16] subsidiary clock stable; await completion
// [RQ17] control bits 7-4, 1-0 read zero
// [RQ18] keep arm clear; verify by readback
// [RQ19] fixed parameterised length on subsidiary clock
module osp_otp_dev #(
  parameter bit WIDE_HIGH  = 1'b0,
  parameter int PAGE_WORDS = 256,
  parameter int BURN_TICKS = osp_pkg::BURN_TICKS_DEF
) (
  input  wire logic core_clk_i,
  input  wire logic reset_n_i,
  osp_link_if.dev   link,
  output logic      busy_o,
  output logic      fail_o
);
  localparam int AW = $clog2(PAGE_WORDS);
  localparam int CW = $clog2(BURN_TICKS + 1);
  localparam logic [CW-1:0] LAST_TICK = CW'(BURN_TICKS - 1);
  localparam logic [7:0] HI_MASK = WIDE_HIGH ? 8'hff : 8'h7f;

  osp_pkg::osp_dev_state_t state;
  logic [7:0]      tbl_ptr;
  logic [7:0]      word_low;
  logic [7:0]      word_high;
  logic            arm;
  logic            go;
  logic            arm_fresh;
  logic [CW-1:0]   tick_cnt;
  logic [AW-1:0]   burn_addr;
  logic [15:0]     burn_data;
  logic [PAGE_WORDS-1:0] used;
  logic [15:0]     page_mem [PAGE_WORDS];
  logic            sub_s;
  logic            sub_q;
  logic            sleep_s;
  logic            sub_rise;
  logic            wr_ok;
  logic            ctrl_wr;
  logic            start;
  logic            done;
  logic            abort;
  logic [AW-1:0]   rd_idx;

  // the sub_clk and sleep pins from the cpu end pass two flops first
  osp_sync2 u_sync_sub (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .d_i        (link.sub_clk),
    .q_o        (sub_s)
  );
  osp_sync2 u_sync_sleep (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .d_i        (link.sleep),
    .q_o        (sleep_s)
  );

  // subsidiary clock edge detect, on the synchronised copy only
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sub_q <= 1'b0;
    end else begin
      sub_q <= sub_s;
    end
  end
  assign sub_rise = sub_s & ~sub_q;

  // register writes are refused while the cpu is halted
  assign wr_ok   = link.instr_stb & link.reg_wr & ~link.stall;
  assign ctrl_wr = wr_ok & (link.reg_sel == osp_pkg::SEL_CONTROL);

  // [RQ8] needs arm already set
  // [RQ9] arm must predate this write
  // [RQ10] only the instruction right after arm
  assign start = ctrl_wr & link.reg_wdata[osp_pkg::CTRL_GO_BIT]
               & link.reg_wdata[osp_pkg::CTRL_ARM_BIT]
               & arm & arm_fresh & (state == osp_pkg::D_IDLE);

  // [RQ19] fixed tick count ends cycle
  assign done  = (state == osp_pkg::D_BURN) & sub_rise & ~sleep_s
               & (tick_cnt == LAST_TICK);
  // [RQ15] sleep mid-cycle aborts write
  assign abort = (state == osp_pkg::D_BURN) & sleep_s;

  // data and pointer registers
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tbl_ptr   <= osp_pkg::RST_BYTE;
      word_low  <= osp_pkg::RST_BYTE;
      word_high <= osp_pkg::RST_BYTE;
    end else if (wr_ok) begin
      case (link.reg_sel)
        osp_pkg::SEL_TBL_PTR: begin
          tbl_ptr <= link.reg_wdata;
        end
        // [RQ3] full byte low data
        osp_pkg::SEL_WORD_LO: begin
          word_low <= link.reg_wdata;
        end
        // [RQ4] narrow variant drops bit 7
        osp_pkg::SEL_WORD_HI: begin
          word_high <= link.reg_wdata & HI_MASK;
        end
        default: begin
          tbl_ptr <= tbl_ptr;
        end
      endcase
    end
  end

  // arm and go control bits
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      arm <= 1'b0;
      go  <= 1'b0;
    end else if (done || abort) begin
      // [RQ6] arm self-clears at end
      arm <= 1'b0;
      // [RQ7] go clears at completion
      go  <= 1'b0;
    end else if (ctrl_wr) begin
      // [RQ5] arm bit written by software
      arm <= link.reg_wdata[osp_pkg::CTRL_ARM_BIT];
      // [RQ6] no go without arm
      go  <= start;
    end
  end

  // remembers that the previous instruction raised arm; any later one forgets
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      arm_fresh <= 1'b0;
    end else if (link.instr_stb) begin
      // [RQ10] window lasts one instruction
      arm_fresh <= ctrl_wr & ~arm & link.reg_wdata[osp_pkg::CTRL_ARM_BIT];
    end
  end

  // write cycle sequencing and cpu halt
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state      <= osp_pkg::D_IDLE;
      tick_cnt   <= '0;
      link.stall <= 1'b0;
      busy_o     <= 1'b0;
      fail_o     <= 1'b0;
    end else begin
      case (state)
        osp_pkg::D_IDLE: begin
          if (start) begin
            // [RQ11] halt the cpu on activation
            link.stall <= 1'b1;
            busy_o     <= 1'b1;
            fail_o     <= 1'b0;
            tick_cnt   <= '0;
            state      <= osp_pkg::D_BURN;
          end
        end
        osp_pkg::D_BURN: begin
          if (done || abort) begin
            // [RQ11] resume cpu at the end
            link.stall <= 1'b0;
            busy_o     <= 1'b0;
            fail_o     <= abort;
            state      <= osp_pkg::D_IDLE;
          end else if (sub_rise) begin
            tick_cnt <= tick_cnt + CW'(1);
          end
        end
        default: begin
          state <= osp_pkg::D_IDLE;
        end
      endcase
    end
  end

  // [RQ12] latch pointer and word at start
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      burn_addr <= '0;
      burn_data <= 16'h0000;
    end else if (start) begin
      burn_addr <= tbl_ptr[AW-1:0];
      burn_data <= {word_high, word_low};
    end
  end

  // [RQ1] programmed marks, no erase path
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      used <= '0;
    end else if (done) begin
      used[burn_addr] <= 1'b1;
    end
  end

  // store has no reset; the used marks decide what reads back
  always_ff @(posedge core_clk_i) begin
    // [RQ1] a word is programmed once only
    if (done && !used[burn_addr]) begin
      page_mem[burn_addr] <= burn_data;
    end
  end

  assign rd_idx = tbl_ptr[AW-1:0];

  // read answers one cycle after the request
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      link.rd_valid  <= 1'b0;
      link.reg_rdata <= osp_pkg::RST_BYTE;
      link.rd_low    <= osp_pkg::RST_BYTE;
      link.rd_high   <= osp_pkg::RST_BYTE;
    end else begin
      link.rd_valid <= link.instr_stb & (link.reg_rd | link.tab_rd);
      if (link.instr_stb && link.tab_rd) begin
        // [RQ14] low and high bytes apart
        link.rd_low  <= used[rd_idx] ? page_mem[rd_idx][7:0] : osp_pkg::BLANK_BYTE;
        link.rd_high <= used[rd_idx] ? page_mem[rd_idx][15:8] : osp_pkg::BLANK_BYTE;
      end
      if (link.instr_stb && link.reg_rd) begin
        case (link.reg_sel)
          osp_pkg::SEL_TBL_PTR: link.reg_rdata <= tbl_ptr;
          osp_pkg::SEL_WORD_LO: link.reg_rdata <= word_low;
          osp_pkg::SEL_WORD_HI: link.reg_rdata <= word_high;
          // [RQ17] unused control bits read zero
          osp_pkg::SEL_CONTROL: link.reg_rdata <= {4'h0, arm, go, 2'h0};
          default:              link.reg_rdata <= osp_pkg::RST_BYTE;
        endcase
      end
    end
  end
endmodule

//--- logic/osp_otp_host.sv
// cpu end: ahb-lite orders turned into the arm/go instruction sequence
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module osp_otp_host #(
  parameter int SUB_DIV  = osp_pkg::SUB_DIV_DEF,
  parameter int SUB_WARM = osp_pkg::SUB_WARM_DEF
) (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  osp_link_if.host         link,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic             gie_o,
  output logic             vpp_gpio_oe_o
);
  localparam int DW = $clog2(SUB_DIV + 1);
  localparam int WW = $clog2(SUB_WARM + 1);

  osp_pkg::osp_host_state_t state;
  logic [DW-1:0] div_cnt;
  logic [WW-1:0] warm_cnt;
  logic          sub_stable;
  logic [23:0]   word_reg;
  logic [1:0]    ctrl_reg;
  logic          busy;
  logic          vfail;
  logic          verify;
  logic [15:0]   rd_word;
  logic          wr_ph;
  logic [7:0]    wr_off;
  logic          cmd_prog;
  logic          cmd_read;

  // subsidiary clock divider and warm-up count
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt      <= '0;
      link.sub_clk <= 1'b0;
      warm_cnt     <= '0;
      sub_stable   <= 1'b0;
    end else if (div_cnt == DW'(SUB_DIV - 1)) begin
      div_cnt      <= '0;
      link.sub_clk <= ~link.sub_clk;
      if (warm_cnt != WW'(SUB_WARM)) begin
        warm_cnt <= warm_cnt + WW'(1);
      end
      sub_stable <= (warm_cnt == WW'(SUB_WARM));
    end else begin
      div_cnt <= div_cnt + DW'(1);
    end
  end

  // ahb-lite slave: zero wait, always okay
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      hrdata_o    <= 32'h0000_0000;
      wr_ph       <= 1'b0;
      wr_off      <= 8'h00;
    end else begin
      wr_ph <= hsel_i & htrans_i[1] & hready_i & hwrite_i;
      if (hsel_i && htrans_i[1] && hready_i) begin
        wr_off <= haddr_i[7:0];
        if (!hwrite_i) begin
          case (haddr_i[7:0])
            osp_pkg::OFF_WORD: hrdata_o <= {8'h00, word_reg};
            osp_pkg::OFF_STAT: hrdata_o <= {rd_word, 13'h0000, sub_stable, vfail, busy};
            osp_pkg::OFF_CTRL: hrdata_o <= {30'h0000_0000, ctrl_reg};
            default:           hrdata_o <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  assign cmd_prog = wr_ph & (wr_off == osp_pkg::OFF_CMD) & hwdata_i[osp_pkg::CMD_PROG_BIT];
  assign cmd_read = wr_ph & (wr_off == osp_pkg::OFF_CMD) & hwdata_i[osp_pkg::CMD_READ_BIT];

  // software-written word and control registers
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      word_reg <= 24'h00_0000;
      ctrl_reg <= 2'h0;
    end else if (wr_ph && !busy) begin
      if (wr_off == osp_pkg::OFF_WORD) begin
        word_reg <= hwdata_i[23:0];
      end
      if (wr_off == osp_pkg::OFF_CTRL) begin
        ctrl_reg <= hwdata_i[1:0];
      end
    end
  end

  // [RQ2] shared vpp pin never output while busy except in the first busy cycle
  // [RQ15] no sleep while a write runs
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vpp_gpio_oe_o <= 1'b0;
      link.sleep    <= 1'b0;
    end else begin
      vpp_gpio_oe_o <= ctrl_reg[osp_pkg::CTRL_GPIO_BIT] & ~busy;
      link.sleep    <= ctrl_reg[osp_pkg::CTRL_SLEEP_BIT] & ~busy;
    end
  end

  // instruction sequencer, at most one link instruction per state
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state          <= osp_pkg::H_IDLE;
      busy           <= 1'b0;
      vfail          <= 1'b0;
      verify         <= 1'b0;
      rd_word        <= 16'h0000;
      gie_o          <= 1'b1;
      link.instr_stb <= 1'b0;
      link.reg_wr    <= 1'b0;
      link.reg_rd    <= 1'b0;
      link.tab_rd    <= 1'b0;
      link.reg_sel   <= osp_pkg::SEL_TBL_PTR;
      link.reg_wdata <= 8'h00;
    end else begin
      link.instr_stb <= 1'b0;
      link.reg_wr    <= 1'b0;
      link.reg_rd    <= 1'b0;
      link.tab_rd    <= 1'b0;
      case (state)
        osp_pkg::H_IDLE: begin
          if (cmd_prog) begin
            busy  <= 1'b1;
            vfail <= 1'b0;
            state <= osp_pkg::H_WARM;
          end else if (cmd_read) begin
            busy   <= 1'b1;
            verify <= 1'b0;
            state  <= osp_pkg::H_RDPTR;
          end
        end
        // [RQ16] wait for stable subsidiary clock
        osp_pkg::H_WARM: begin
          if (sub_stable) begin
            // [RQ13] interrupts off before arming
            gie_o  <= 1'b0;
            verify <= 1'b1;
            state  <= osp_pkg::H_PTR;
          end
        end
        // [RQ12] pointer and data loaded first
        osp_pkg::H_PTR: begin
          link.instr_stb <= 1'b1;
          link.reg_wr    <= 1'b1;
          link.reg_sel   <= osp_pkg::SEL_TBL_PTR;
          link.reg_wdata <= word_reg[23:16];
          state          <= osp_pkg::H_LOW;
        end
        osp_pkg::H_LOW: begin
          link.instr_stb <= 1'b1;
          link.reg_wr    <= 1'b1;
          link.reg_sel   <= osp_pkg::SEL_WORD_LO;
          link.reg_wdata <= word_reg[7:0];
          state          <= osp_pkg::H_HIGH;
        end
        osp_pkg::H_HIGH: begin
          link.instr_stb <= 1'b1;
          link.reg_wr    <= 1'b1;
          link.reg_sel   <= osp_pkg::SEL_WORD_HI;
          link.reg_wdata <= word_reg[15:8];
          state          <= osp_pkg::H_CLR;
        end
        osp_pkg::H_CLR: begin
          link.instr_stb <= 1'b1;
          link.reg_wr    <= 1'b1;
          link.reg_sel   <= osp_pkg::SEL_CONTROL;
          link.reg_wdata <= 8'h00;
          state          <= osp_pkg::H_ARM;
        end
        osp_pkg::H_ARM: begin
          link.instr_stb <= 1'b1;
          link.reg_wr    <= 1'b1;
          link.reg_wdata <= 8'h08;
          state          <= osp_pkg::H_GO;
        end
        // [RQ10] go follows arm directly
        osp_pkg::H_GO: begin
          link.instr_stb <= 1'b1;
          link.reg_wr    <= 1'b1;
          link.reg_wdata <= 8'h0c;
          state          <= osp_pkg::H_HOLD;
        end
        // stall shows one cycle after the go write lands
        osp_pkg::H_HOLD: begin
          state <= osp_pkg::H_WAIT;
        end
        osp_pkg::H_WAIT: begin
          if (!link.stall) begin
            // [RQ13] interrupts back after activation
            gie_o <= 1'b1;
            state <= osp_pkg::H_RD;
          end
        end
        osp_pkg::H_RDPTR: begin
          link.instr_stb <= 1'b1;
          link.reg_wr    <= 1'b1;
          link.reg_sel   <= osp_pkg::SEL_TBL_PTR;
          link.reg_wdata <= word_reg[23:16];
          state          <= osp_pkg::H_RD;
        end
        osp_pkg::H_RD: begin
          link.instr_stb <= 1'b1;
          link.tab_rd    <= 1'b1;
          // [RQ17] select still names control after a write: read it too
          link.reg_rd    <= 1'b1;
          state          <= osp_pkg::H_RDW;
        end
        // [RQ18] readback verifies the new word
        osp_pkg::H_RDW: begin
          if (link.rd_valid) begin
            rd_word <= {link.rd_high, link.rd_low};
            vfail   <= verify & ({link.rd_high, link.rd_low} != word_reg[15:0]);
            busy    <= 1'b0;
            state   <= osp_pkg::H_IDLE;
          end
        end
        default: begin
          state <= osp_pkg::H_IDLE;
        end
      endcase
    end
  end
endmodule

//--- dv/osp_link_checker.sv
// assertions on the link between the cpu end and the otp device end
`timescale 1ns/1ps
module osp_link_checker (
  input wire logic       core_clk_i,
  input wire logic       reset_n_i,
  input wire logic       instr_stb,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic       tab_rd,
  input wire logic [2:0] reg_sel,
  input wire logic [7:0] reg_wdata,
  input wire logic       sleep,
  input wire logic       stall,
  input wire logic       rd_valid,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] rd_high
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  // decoded instructions; the arm/go pattern is the host's fixed 00, 08, 0c run
  wire logic rd_req  = instr_stb & (reg_rd | tab_rd);
  wire logic tab_req = instr_stb & tab_rd;
  wire logic ctrl_rd = instr_stb & reg_rd & (reg_sel == osp_pkg::SEL_CONTROL);
  wire logic ctrl_wr = instr_stb & reg_wr & (reg_sel == osp_pkg::SEL_CONTROL);
  wire logic clr_wr  = ctrl_wr & (reg_wdata == 8'h00);
  wire logic arm_wr  = ctrl_wr & (reg_wdata == 8'h08);
  wire logic go_wr   = ctrl_wr & (reg_wdata == 8'h0c);

  read_answer_a: assert property (rd_req |=> rd_valid)
    else $error("read not answered next cycle");
  read_cause_a: assert property (rd_valid |-> $past(rd_req))
    else $error("read answer without request");
  ctrl_unused_a: assert property (rd_valid && $past(ctrl_rd) |->
    reg_rdata[7:4] == 4'h0 && reg_rdata[1:0] == 2'h0) else $error("unused control bits set");
  ctrl_done_a: assert property (rd_valid && $past(ctrl_rd) && !stall |->
    reg_rdata[3:2] == 2'b00) else $error("control bits not cleared after write");
  high_bit7_a: assert property (rd_valid && $past(tab_req) |-> rd_high[7] == 1'b0)
    else $error("narrow high byte bit 7 set");
  start_seq_a: assert property (!stall && clr_wr ##1 arm_wr ##1 go_wr |=> stall)
    else $error("valid arm then go did not halt cpu");
  start_cause_a: assert property ($rose(stall) |-> $past(go_wr) && $past(arm_wr, 2))
    else $error("write cycle started without arm then go");
  stall_min_a: assert property ($rose(stall) |-> stall[*4])
    else $error("write cycle shorter than its tick count");
  stall_end_a: assert property ($rose(stall) |-> ##[4:100] !stall)
    else $error("write cycle never ended");
  halt_cpu_a: assert property (stall && $past(stall) |-> !instr_stb)
    else $error("instruction issued while halted");
  sleep_off_a: assert property (stall |-> !sleep)
    else $error("cpu asleep during write cycle");

  cover property (go_wr);
  cover property ($fell(stall));
  cover property (tab_req ##1 rd_valid);
endmodule

//--- dv/otp_self_program_control_tb_top.sv
// self-checking bench: ahb orders drive both ends of the otp link
`timescale 1ns/1ps
module otp_self_program_control_tb_top;
  logic        core_clk;
  logic        reset_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        gie;
  logic        vpp_oe;
  logic        busy;
  logic        fail;
  logic [31:0] rd;
  int          fails;
  int          checks_done;

  osp_link_if link_if (.core_clk_i(core_clk), .reset_n_i(reset_n));
  // short tick counts keep each write cycle under a dozen clocks
  osp_otp_dev #(.BURN_TICKS(2)) osp_otp_dev_i (.core_clk_i(core_clk), .reset_n_i(reset_n),
    .link(link_if.dev), .busy_o(busy), .fail_o(fail));
  osp_otp_host #(.SUB_DIV(2), .SUB_WARM(1)) osp_otp_host_i (.core_clk_i(core_clk),
    .reset_n_i(reset_n), .link(link_if.host), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .gie_o(gie), .vpp_gpio_oe_o(vpp_oe));
  osp_link_checker osp_link_checker_i (.core_clk_i(core_clk), .reset_n_i(reset_n),
    .instr_stb(link_if.instr_stb), .reg_wr(link_if.reg_wr), .reg_rd(link_if.reg_rd),
    .tab_rd(link_if.tab_rd), .reg_sel(link_if.reg_sel), .reg_wdata(link_if.reg_wdata),
    .stall(link_if.stall), .rd_valid(link_if.rd_valid), .reg_rdata(link_if.reg_rdata),
    .rd_high(link_if.rd_high), .sleep(link_if.sleep));

  // 250 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // hready is read just after the edge, so it is the value that edge sampled
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      fails++;
      give_verdict();
    end
  endtask

  // one single-word transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  // poll status until idle; while the cpu is halted interrupts and the pin drive stay off
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      ahb(1'b0, osp_pkg::OFF_STAT, 32'h0);
      if (link_if.stall === 1'b1) begin
        chk({31'h0, gie}, 32'h0);
        chk({31'h0, vpp_oe}, 32'h0);
      end
      n++;
    end while (rd[osp_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 100);
    if (n >= 100) begin
      fails++;
      give_verdict();
    end
  endtask

  task automatic prog(input logic [7:0] a, input logic [15:0] w);
    ahb(1'b1, osp_pkg::OFF_WORD, {8'h0, a, w});
    ahb(1'b1, osp_pkg::OFF_CMD, 32'h1);
    wait_idle();
  endtask

  // read one stored word back through the table read; it lands in status [31:16]
  task automatic readback(input logic [7:0] a, input logic [15:0] exp);
    ahb(1'b1, osp_pkg::OFF_WORD, {8'h0, a, 16'h0});
    ahb(1'b1, osp_pkg::OFF_CMD, 32'h2);
    wait_idle();
    chk({16'h0, rd[31:16]}, {16'h0, exp});
  endtask

  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    fails = 0;
    checks_done = 0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    chk({30'h0, gie, vpp_oe}, 32'h2);
    // status clear after reset, then wait for the subsidiary clock to settle
    ahb(1'b0, osp_pkg::OFF_STAT, 32'h0);
    chk(rd & 32'h3, 32'h0);
    for (int i = 0; i < 50 && rd[osp_pkg::STAT_STABLE_BIT] !== 1'b1; i++) begin
      ahb(1'b0, osp_pkg::OFF_STAT, 32'h0);
    end
    chk({31'h0, rd[osp_pkg::STAT_STABLE_BIT]}, 32'h1);
    $display("test reset done");
    // narrow high byte drops bit 7; data and address reach the store
    // the dropped bit 7 makes the readback differ, so verify must flag it
    prog(8'h05, 16'hda3c);
    chk({31'h0, rd[osp_pkg::STAT_VFAIL_BIT]}, 32'h1);
    readback(8'h05, 16'h5a3c);
    $display("test program done");
    // a used word cannot be written twice; blank words read zero
    prog(8'h05, 16'h00ff);
    readback(8'h05, 16'h5a3c);
    readback(8'hff, 16'h0000);
    prog(8'hff, 16'hffa5);
    readback(8'hff, 16'h7fa5);
    $display("test once done");
    // pin drive request is honoured when idle and gated during the write
    ahb(1'b1, osp_pkg::OFF_CTRL, 32'h2);
    ahb(1'b0, osp_pkg::OFF_STAT, 32'h0);
    chk({31'h0, vpp_oe}, 32'h1);
    prog(8'h10, 16'h0102);
    chk({31'h0, rd[osp_pkg::STAT_VFAIL_BIT]}, 32'h0);
    readback(8'h10, 16'h0102);
    ahb(1'b1, osp_pkg::OFF_CTRL, 32'h0);
    $display("test pin done");
    // unmapped place reads zero and drops writes
    ahb(1'b1, 8'h20, 32'hffff_ffff);
    ahb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    chk({30'h0, hresp, fail}, 32'h0);
    $display("test unmapped done");
    give_verdict();
  end
endmodule
